/* hdl/wtp_i2c_window_target_port.sv */
// I2C target port with ready-line communication windows, timeout and event mode.
`timescale 1ns/1ns

module wtp_i2c_window_target_port #(
  parameter int CYC_PER_MS = wtp_pkg::CYC_PER_MS_DEF  // Clock cycles per millisecond.
) (
  input  wire logic                            clk,         // System clock.
  input  wire logic                            rstn,        // Asynchronous reset, active low.
  input  wire logic                            scl_i,       // Clock pin level.
  input  wire logic                            sda_i,       // Data pin level.
  output wire logic                            sda_o,       // Data pin drive value.
  output wire logic                            sda_oe,      // High while pulling data low.
  output wire logic                            rdy_o,       // Ready pin drive value.
  output wire logic                            rdy_oe,      // High while pulling ready low.
  input  wire logic                            report_tick, // Report-rate cycle pulse.
  input  wire logic [wtp_pkg::NUM_EVENTS-1:0]  event_in,    // Event pulses from the core.
  input  wire wtp_pkg::wtp_cfg_t               cfg,         // Settings and status bits.
  output wire logic [15:0]                     reg_addr,    // Read address to the map.
  output wire logic                            reg_rd,      // Read strobe, one cycle.
  input  wire logic [7:0]                      reg_rdata,   // Read data from the map.
  input  wire logic                            reg_hit,     // Address exists in the map.
  output wire wtp_pkg::wtp_wr_t                reg_wr,      // Register write strobe.
  output wire logic                            win_open,    // Window open status.
  output wire logic                            force_wait   // Forced window pending.
);

  wtp_pkg::wtp_state_t s;
  wtp_pkg::wtp_state_t next_s;

  logic       rise;
  logic       fall;
  logic       start_c;
  logic       stop_c;
  logic       ms_tick;
  logic       ev_hit;
  logic       stream_like;
  logic [7:0] tx_byte;

  localparam int MS_CNT_W = wtp_pkg::MS_CNT_W;

  // Byte sent to the host: the register value only for a mapped address inside a window.
  function automatic logic [7:0] wtp_tx_sel(input logic in_win, input logic hit, input logic [7:0] data);
    if (in_win && hit) begin
      return data;
    end
    return wtp_pkg::INVALID_BYTE;
  endfunction

  assign rise = s.scl_s & ~s.scl_p;
  assign fall = ~s.scl_s & s.scl_p;
  assign start_c = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s;
  assign stop_c = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s;
  assign ms_tick = (s.ms_cnt == MS_CNT_W'(CYC_PER_MS - 1));
  assign ev_hit = |(event_in & cfg.event_mask);
  // Until the reset indicator is acknowledged and flags are read, event mode acts as streaming.
  assign stream_like = ~cfg.event_mode | cfg.show_reset | cfg.flags_pending;
  assign tx_byte = wtp_tx_sel(s.win, reg_hit, reg_rdata);

  always_comb begin
    logic load;
    logic close;
    load = 1'b0;
    close = 1'b0;
    next_s = s;
    next_s.wr.we = 1'b0;
    next_s.scl_m = scl_i;
    next_s.scl_s = s.scl_m;
    next_s.scl_p = s.scl_s;
    next_s.sda_m = sda_i;
    next_s.sda_s = s.sda_m;
    next_s.sda_p = s.sda_s;
    next_s.ms_cnt = ms_tick ? wtp_pkg::MS_CNT_RST : s.ms_cnt + MS_CNT_W'(1);

    if (start_c) begin
      next_s.ph = wtp_pkg::WTP_ADDR;
      next_s.bitc = wtp_pkg::BITC_RST;
      next_s.oe = 1'b0;
    end else if (stop_c) begin
      next_s.ph = wtp_pkg::WTP_IDLE;
      next_s.oe = 1'b0;
      if (!s.rw && s.nrx == 2'h1 && s.first_ff) begin
        next_s.force_req = 1'b1;
      end
      if (s.win && cfg.close_on_stop) begin
        close = 1'b1;
      end
    end else if (rise) begin
      unique case (s.ph)
        wtp_pkg::WTP_ADDR, wtp_pkg::WTP_RX: begin
          next_s.sh = {s.sh[6:0], s.sda_s};
          next_s.bitc = s.bitc + 4'h1;
        end
        wtp_pkg::WTP_TX: begin
          next_s.bitc = s.bitc + 4'h1;
        end
        wtp_pkg::WTP_TACK: begin
          next_s.mack = ~s.sda_s;
        end
        wtp_pkg::WTP_IDLE, wtp_pkg::WTP_AACK, wtp_pkg::WTP_RACK: begin
        end
        default: begin
          next_s.ph = wtp_pkg::WTP_IDLE;
        end
      endcase
    end else if (fall) begin
      unique case (s.ph)
        wtp_pkg::WTP_ADDR: begin
          if (s.bitc == wtp_pkg::BITS_PER_BYTE) begin
            if (s.sh[7:1] == wtp_pkg::TARGET_ADDR) begin
              next_s.oe = 1'b1;
              next_s.rw = s.sh[0];
              next_s.ph = wtp_pkg::WTP_AACK;
            end else begin
              next_s.ph = wtp_pkg::WTP_IDLE;
            end
          end
        end
        wtp_pkg::WTP_AACK: begin
          next_s.bitc = wtp_pkg::BITC_RST;
          if (s.rw) begin
            load = 1'b1;
            next_s.ph = wtp_pkg::WTP_TX;
          end else begin
            next_s.oe = 1'b0;
            next_s.nrx = wtp_pkg::NRX_RST;
            next_s.ph = wtp_pkg::WTP_RX;
          end
        end
        wtp_pkg::WTP_RX: begin
          if (s.bitc == wtp_pkg::BITS_PER_BYTE) begin
            next_s.oe = 1'b1;
            next_s.ph = wtp_pkg::WTP_RACK;
            next_s.nrx = (s.nrx == wtp_pkg::RX_CNT_MAX) ? s.nrx : s.nrx + 2'h1;
            unique case (s.nrx)
              2'h0: begin
                next_s.ptr[7:0] = s.sh;
                next_s.first_ff = (s.sh == wtp_pkg::FORCE_BYTE);
              end
              2'h1: begin
                next_s.ptr[15:8] = s.sh;
              end
              default: begin
                next_s.wr.we = 1'b1;
                next_s.wr.addr = s.ptr;
                next_s.wr.data = s.sh;
                next_s.ptr = s.ptr + 16'h0001;
              end
            endcase
          end
        end
        wtp_pkg::WTP_RACK: begin
          next_s.oe = 1'b0;
          next_s.bitc = wtp_pkg::BITC_RST;
          next_s.ph = wtp_pkg::WTP_RX;
        end
        wtp_pkg::WTP_TX: begin
          if (s.bitc == wtp_pkg::BITS_PER_BYTE) begin
            next_s.oe = 1'b0;
            next_s.ph = wtp_pkg::WTP_TACK;
          end else begin
            next_s.txsh = {s.txsh[6:0], 1'b0};
            next_s.oe = ~s.txsh[6];
          end
        end
        wtp_pkg::WTP_TACK: begin
          if (s.mack) begin
            load = 1'b1;
            next_s.bitc = wtp_pkg::BITC_RST;
            next_s.ph = wtp_pkg::WTP_TX;
          end else begin
            next_s.ph = wtp_pkg::WTP_IDLE;
          end
        end
        wtp_pkg::WTP_IDLE: begin
        end
        default: begin
          next_s.ph = wtp_pkg::WTP_IDLE;
        end
      endcase
    end

    // Loading happens on the falling edge, so the first bit is on the line before the next rise.
    if (load) begin
      next_s.txsh = tx_byte;
      next_s.oe = ~tx_byte[7];
      next_s.ptr = s.ptr + 16'h0001;
    end

    if (s.win) begin
      if (start_c) begin
        next_s.tmo = wtp_pkg::TMO_RST;
      end else if (ms_tick) begin
        if (s.tmo + 16'h0001 >= cfg.timeout_ms) begin
          close = 1'b1;
        end else begin
          next_s.tmo = s.tmo + 16'h0001;
        end
      end
    end
    if (close) begin
      next_s.win = 1'b0;
    end

    // A report or event in the cycle the window closes is ignored; only an already closed window can open.
    if (!s.win) begin
      if (s.force_req && ms_tick) begin
        next_s.win = 1'b1;
        next_s.force_req = 1'b0;
        next_s.tmo = wtp_pkg::TMO_RST;
      end else if (!cfg.halt_mode && ((report_tick && stream_like) || (cfg.event_mode && ev_hit))) begin
        next_s.win = 1'b1;
        next_s.tmo = wtp_pkg::TMO_RST;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
             ph: wtp_pkg::WTP_IDLE, bitc: wtp_pkg::BITC_RST, sh: wtp_pkg::BYTE_RST,
             txsh: wtp_pkg::BYTE_RST, rw: 1'b0, mack: 1'b0, nrx: wtp_pkg::NRX_RST,
             first_ff: 1'b0, ptr: wtp_pkg::PTR_RST, oe: 1'b0, win: 1'b0,
             tmo: wtp_pkg::TMO_RST, ms_cnt: wtp_pkg::MS_CNT_RST, force_req: 1'b0,
             wr: '{we: 1'b0, addr: wtp_pkg::PTR_RST, data: wtp_pkg::BYTE_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = s.oe;
  assign rdy_o = 1'b0;
  assign rdy_oe = s.win;
  assign reg_addr = s.ptr;
  assign reg_rd = (fall && !start_c && !stop_c && ((s.ph == wtp_pkg::WTP_AACK && s.rw) ||
                                                  (s.ph == wtp_pkg::WTP_TACK && s.mack)));
  assign reg_wr = s.wr;
  assign win_open = s.win;
  assign force_wait = s.force_req;

endmodule

/* hdl/wtp_pkg.sv */
// Shared constants, state and carrier types of the windowed I2C target port.
package wtp_pkg;

  // Target address and special byte values.
  localparam logic [6:0]  TARGET_ADDR = 7'h56;
  localparam logic [7:0]  INVALID_BYTE = 8'hEE;
  localparam logic [7:0]  FORCE_BYTE = 8'hFF;

  // Clock and millisecond timing.
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MS_NS = 1000000;
  localparam int          CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int          MS_CNT_W = 17;
  localparam logic [15:0] TIMEOUT_MS_DEF = 16'h00FA;

  // Field widths and positions.
  localparam int          NUM_EVENTS = 5;
  localparam int          EV_POWER = 0;
  localparam int          EV_TUNING = 1;
  localparam int          EV_TOUCH = 2;
  localparam int          EV_PROX = 3;
  localparam int          EV_HAPTIC = 4;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [1:0]  RX_CNT_MAX = 2'h2;

  // Reset values.
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [3:0]  BITC_RST = 4'h0;
  localparam logic [1:0]  NRX_RST = 2'h0;
  localparam logic [15:0] TMO_RST = 16'h0000;
  localparam logic [MS_CNT_W-1:0] MS_CNT_RST = '0;

  typedef enum logic [2:0] {
    WTP_IDLE = 3'b000,
    WTP_ADDR = 3'b001,
    WTP_AACK = 3'b010,
    WTP_RX   = 3'b011,
    WTP_RACK = 3'b100,
    WTP_TX   = 3'b101,
    WTP_TACK = 3'b110
  } wtp_ph_t;

  // Settings and status bits supplied by the device core.
  typedef struct packed {
    logic                  event_mode;
    logic                  halt_mode;
    logic                  close_on_stop;
    logic                  show_reset;
    logic                  flags_pending;
    logic [NUM_EVENTS-1:0] event_mask;
    logic [15:0]           timeout_ms;
  } wtp_cfg_t;

  // Register write strobe toward the register map.
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } wtp_wr_t;

  // Whole state of the port.
  typedef struct packed {
    logic                scl_m;
    logic                scl_s;
    logic                scl_p;
    logic                sda_m;
    logic                sda_s;
    logic                sda_p;
    wtp_ph_t             ph;
    logic [3:0]          bitc;
    logic [7:0]          sh;
    logic [7:0]          txsh;
    logic                rw;
    logic                mack;
    logic [1:0]          nrx;
    logic                first_ff;
    logic [15:0]         ptr;
    logic                oe;
    logic                win;
    logic [15:0]         tmo;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic                force_req;
    wtp_wr_t             wr;
  } wtp_state_t;

endpackage

/* bench/wtp_chk_asserts.sv */
// Assertion checker bound to the windowed I2C target port.
`timescale 1ns/1ns
module wtp_chk #(
  parameter int CYC_PER_MS = 20 // Cycles per ms.
) (
  input wire logic                          clk,         // Clock.
  input wire logic                          rstn,        // Reset.
  input wire logic                          scl_i,       // Clock pin.
  input wire logic                          sda_i,       // Data pin.
  input wire logic                          rdy_oe,      // Ready low.
  input wire logic                          win_open,    // Window.
  input wire logic                          report_tick, // Tick.
  input wire logic [wtp_pkg::NUM_EVENTS-1:0] event_in,   // Events.
  input wire wtp_pkg::wtp_cfg_t             cfg,         // Settings.
  input wire logic                          force_wait,  // Forced wait.
  input wire logic                          reg_rd,      // Read strobe.
  input wire logic [15:0]                   reg_addr     // Pointer.
);
  localparam int FW = CYC_PER_MS + 2;
  logic ev;
  logic shut;
  logic strm;
  assign ev = |(event_in & cfg.event_mask);
  assign shut = !win_open && !cfg.halt_mode;
  assign strm = !cfg.event_mode || cfg.show_reset || cfg.flags_pending;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence stop_s;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence
  chk_rdy_win: assert property (rdy_oe == win_open)
    else $error("ready differs from window");
  chk_tick_open: assert property (shut && report_tick && strm |=> win_open)
    else $error("tick did not open window");
  chk_event_open: assert property (shut && cfg.event_mode && ev |=> win_open)
    else $error("event did not open window");
  chk_event_quiet: assert property (!win_open && !strm && !ev && !force_wait |=> !win_open)
    else $error("window opened without event");
  chk_halt_block: assert property (cfg.halt_mode && !win_open && !force_wait |=> !win_open)
    else $error("window opened in halt");
  chk_force_open: assert property (force_wait && !win_open |-> ##[1:FW] win_open)
    else $error("forced window late");
  chk_rd_incr: assert property (reg_rd |=> reg_addr == $past(reg_addr) + 16'h0001)
    else $error("pointer did not advance");
  chk_stop_close: assert property (stop_s ##0 (cfg.close_on_stop && win_open) |-> ##[1:8] !win_open)
    else $error("stop did not close window");
endmodule
bind wtp_i2c_window_target_port wtp_chk #(.CYC_PER_MS(CYC_PER_MS)) i_wtp_chk (
  .clk(clk), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i), .rdy_oe(rdy_oe), .win_open(win_open),
  .report_tick(report_tick), .event_in(event_in), .cfg(cfg), .force_wait(force_wait),
  .reg_rd(reg_rd), .reg_addr(reg_addr));

/* bench/wtp_host.sv */
// I2C host model that drives the target port.
`timescale 1ns/1ns
module wtp_host (
  input  wire logic clk, // Clock.
  input  wire logic sda, // Data wire.
  output logic      scl, // Clock drive.
  output logic      sdo  // Data drive, high releases.
);
  initial begin
    scl = 1'b1;
    sdo = 1'b1;
  end
  task automatic q();
    repeat (5) @(posedge clk);
  endtask
  // Clock is left high between frames; each start first pulls it low, giving edges that the idle port ignores.
  task automatic pins(input logic [7:0] v);
    for (int i = 3; i >= 0; i--) begin
      {scl, sdo} <= v[2*i+:2];
      q();
    end
  endtask
  task automatic start();
    pins(8'h78);
  endtask
  task automatic stop();
    pins(8'h2f);
  endtask
  task automatic bit1(input logic b, output logic r);
    sdo <= b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit1(v[i], r);
    bit1(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit1(1'b1, v[i]);
    bit1(!ack, r);
  endtask
  task automatic ptr(input logic [15:0] a, output logic ok);
    logic k0, k1, k2;
    start();
    wbyte({wtp_pkg::TARGET_ADDR, 1'b0}, k0);
    wbyte(a[7:0], k1);
    wbyte(a[15:8], k2);
    ok = k0 & k1 & k2;
  endtask
endmodule

/* bench/tb.sv */
// Self-checking bench for the windowed I2C target port.
`timescale 1ns/1ns
module tb;
  logic clk, rstn, scl, sdm, sda, sda_oe, rdy_oe, win_open, force_wait, report_tick, reg_rd, reg_hit, ak;
  logic [4:0] event_in;
  logic [7:0] reg_rdata, b;
  logic [7:0] d [3];
  logic [15:0] reg_addr, a;
  logic [23:0] wq [$];
  logic [31:0] lf = 32'h0000_96a5;
  wtp_pkg::wtp_cfg_t cfg;
  wtp_pkg::wtp_wr_t reg_wr;
  int err_count, total_checks, cyc, i, k;
  assign sda = sdm & ~sda_oe;
  assign reg_hit = reg_addr[15:12] == 4'h1;
  assign reg_rdata = reg_addr[7:0] ^ 8'h5a;
  wtp_i2c_window_target_port #(.CYC_PER_MS(20)) i_wtp_i2c_window_target_port (
    .clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .rdy_o(), .rdy_oe(rdy_oe),
    .report_tick(report_tick), .event_in(event_in), .cfg(cfg), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .reg_wr(reg_wr), .win_open(win_open), .force_wait(force_wait));
  wtp_host i_wtp_host (.clk(clk), .sda(sda), .scl(scl), .sdo(sdm));
  always #5 clk = ~clk;
  always @(posedge clk) if (reg_wr.we) wq.push_back({reg_wr.addr, reg_wr.data});
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      finish_test();
    end
  end
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function automatic logic [7:0] exp_rd(input logic [15:0] ad, input logic open);
    return (open && ad[15:12] == 4'h1) ? ad[7:0] ^ 8'h5a : wtp_pkg::INVALID_BYTE;
  endfunction
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Samples on the falling edge so the window flag has settled.
  task automatic wt(input logic v, input int n);
    @(negedge clk);
    repeat (n) if (win_open !== v) @(negedge clk);
    chk("window", win_open, v);
    @(posedge clk);
  endtask
  task automatic tick();
    report_tick <= 1'b1;
    @(posedge clk);
    report_tick <= 1'b0;
  endtask
  task automatic rd_at(input logic [15:0] ad);
    i_wtp_host.ptr(ad, ak);
    i_wtp_host.start();
    i_wtp_host.wbyte(8'had, ak);
    chk("read ack", ak, 1'b1);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    report_tick = 1'b0;
    event_in = '0;
    cfg = '0;
    cfg.timeout_ms = 16'h0100;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("reset", {rdy_oe, sda_oe, force_wait, win_open}, 4'h0);
    $display("reset test done");
    tick();
    wt(1'b1, 5);
    a = 16'(rnd());
    i_wtp_host.ptr(a, ak);
    chk("addr ack", ak, 1'b1);
    for (i = 0; i < 3; i++) begin
      d[i] = 8'(rnd());
      i_wtp_host.wbyte(d[i], ak);
      chk("data ack", ak, 1'b1);
    end
    i_wtp_host.stop();
    repeat (10) @(posedge clk);
    chk("writes", 24'(wq.size()), 24'h3);
    for (i = 0; i < 3; i++) chk("write", wq.pop_front(), {a + 16'(i), d[i]});
    wt(1'b1, 1);
    $display("write test done");
    rd_at(16'h1000);
    i_wtp_host.rbyte(1'b1, d[0]);
    chk("rmw read", d[0], exp_rd(16'h1000, 1'b1));
    i_wtp_host.rbyte(1'b0, d[1]);
    chk("rmw read", d[1], exp_rd(16'h1001, 1'b1));
    i_wtp_host.ptr(16'h1000, ak);
    i_wtp_host.wbyte(d[0] | 8'h01, ak);
    i_wtp_host.wbyte((d[1] & 8'hf8) | 8'h02, ak);
    i_wtp_host.stop();
    repeat (10) @(posedge clk);
    chk("rmw writes", 24'(wq.size()), 24'h2);
    chk("rmw ack", wq.pop_front(), {16'h1000, exp_rd(16'h1000, 1'b1) | 8'h01});
    chk("rmw mode", wq.pop_front(), {16'h1001, (exp_rd(16'h1001, 1'b1) & 8'hf8) | 8'h02});
    wt(1'b1, 1);
    $display("modify test done");
    for (k = 0; k < 4; k++) begin
      a = (k == 0) ? 16'h10ff : (k == 1) ? 16'h1fff : 16'(rnd());
      if (k == 3) cfg.close_on_stop <= 1'b1;
      rd_at(a);
      for (i = 0; i < 3; i++) begin
        i_wtp_host.rbyte(i < 2, b);
        chk("read", b, exp_rd(a + 16'(i), 1'b1));
      end
      i_wtp_host.stop();
    end
    wt(1'b0, 10);
    rd_at(16'h1000);
    i_wtp_host.rbyte(1'b0, b);
    chk("closed read", b, exp_rd(16'h1000, 1'b0));
    i_wtp_host.start();
    i_wtp_host.wbyte(8'hae, ak);
    chk("other addr", ak, 1'b0);
    i_wtp_host.stop();
    $display("read test done");
    cfg.timeout_ms <= 16'h0003;
    tick();
    wt(1'b1, 5);
    repeat (35) @(posedge clk);
    wt(1'b1, 1);
    wt(1'b0, 30);
    $display("timeout test done");
    cfg.timeout_ms <= 16'h0001;
    cfg.event_mode <= 1'b1;
    for (k = 0; k < 5; k++) begin
      cfg.event_mask <= 5'(1 << k);
      event_in <= ~5'(1 << k);
      tick();
      event_in <= '0;
      wt(1'b0, 3);
      event_in <= 5'(1 << k);
      @(posedge clk);
      event_in <= '0;
      wt(1'b1, 3);
      wt(1'b0, 30);
    end
    for (k = 1; k < 3; k++) begin
      {cfg.show_reset, cfg.flags_pending} <= 2'(k);
      tick();
      wt(1'b1, 3);
      wt(1'b0, 30);
    end
    {cfg.show_reset, cfg.flags_pending} <= 2'h0;
    $display("event test done");
    cfg.halt_mode <= 1'b1;
    tick();
    wt(1'b0, 3);
    i_wtp_host.start();
    i_wtp_host.wbyte(8'hac, ak);
    i_wtp_host.wbyte(wtp_pkg::FORCE_BYTE, ak);
    i_wtp_host.stop();
    wt(1'b1, 40);
    $display("force test done");
    finish_test();
  end
endmodule
